//--- rtl/ccs_consts.svh
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ---------------------------------------------------------
// Register indices
// ---------------------------------------------------------
`define CCS_IDX_CTRL_ONE   4'h0
`define CCS_IDX_CTRL_TWO   4'h1
`define CCS_IDX_VECTOR     4'h2
`define CCS_IDX_FIFO_CTRL  4'h3
`define CCS_IDX_FIFO_STAT  4'h4
`define CCS_IDX_INT_STAT   4'h5
`define CCS_IDX_INT_MASK   4'h6

// ---------------------------------------------------------
// Field positions
// ---------------------------------------------------------
`define CCS_BIT_STOP_IDLE  13
`define CCS_BIT_ABORT      12
`define CCS_REQ_HI         10
`define CCS_REQ_LO         8
`define CCS_CUR_HI         7
`define CCS_CUR_LO         5
`define CCS_BIT_CAPTURE    3
`define CCS_BIT_WINDOW     0
`define CCS_SIZE_HI        15
`define CCS_SIZE_LO        13
`define CCS_START_HI       4
`define CCS_START_LO       0
`define CCS_DEPTH_HI       4
`define CCS_DEPTH_LO       0
`define CCS_HIT_HI         12
`define CCS_HIT_LO         8
`define CCS_CODE_HI        6
`define CCS_CODE_LO        0
`define CCS_WRP_HI         12
`define CCS_WRP_LO         8
`define CCS_RDP_HI         4
`define CCS_RDP_LO         0
`define CCS_ST_BUF         0
`define CCS_ST_ERR         1
`define CCS_ST_WAKE        2
`define CCS_ST_OVF         3
`define CCS_ST_FIFO_AF     4
`define CCS_ST_RX          5

// ---------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------
`define CCS_RST_DEPTH      5'h00
`define CCS_DEPTH_MAX      5'h11
`define CCS_RST_SIZE       3'h0
`define CCS_SIZE_RSVD      3'h7
`define CCS_RST_START      5'h00
`define CCS_RST_HIT        5'h00
`define CCS_FILTER_MAX     5'h0F
`define CCS_IC_NONE        7'h40
`define CCS_IC_ERROR       7'h41
`define CCS_IC_WAKE        7'h42
`define CCS_IC_OVERFLOW    7'h43
`define CCS_IC_FIFO_AF     7'h44
`define CCS_INT_BITS       6

`endif

//--- rtl/ccs_pkg.sv
`default_nettype none

package ccs_pkg;

  // Operating modes, shared by request and report fields
  typedef enum logic [2:0] {
    CCS_MODE_NORMAL  = 3'b000,
    CCS_MODE_DISABLE = 3'b001,
    CCS_MODE_LOOP    = 3'b010,
    CCS_MODE_LISTEN  = 3'b011,
    CCS_MODE_CONFIG  = 3'b100,
    CCS_MODE_RSVD5   = 3'b101,
    CCS_MODE_RSVD6   = 3'b110,
    CCS_MODE_ALL     = 3'b111
  } ccs_mode_t;

  // Protocol engine condition levels
  typedef struct packed {
    logic bus_idle;
    logic tx_busy;
    logic abort_done;
  } ccs_eng_t;

  // Protocol engine event pulses
  typedef struct packed {
    logic       rx_done;
    logic [4:0] rx_hit;
    logic       fifo_wr;
    logic       fifo_rd;
    logic       err;
    logic       wake;
    logic       ovf;
    logic       fifo_af;
  } ccs_evt_t;

  // Register port
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ccs_req_t;

endpackage : ccs_pkg

`default_nettype wire

//--- rtl/ccs_regs.sv
// Decided for this implementation: the strobed register port and the register addresses.
`include "ccs_consts.svh"
`default_nettype none

module ccs_regs (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port
  input  var  ccs_pkg::ccs_req_t req,
  output logic [15:0]           reg_rdata,
  // Protocol engine
  input  var  ccs_pkg::ccs_eng_t eng,
  input  var  ccs_pkg::ccs_evt_t evt,
  input  wire logic [15:0]      buf_pending,
  input  wire logic             device_idle,
  // Control outputs
  output logic                  module_halt,
  output logic                  abort_all_tx,
  output logic                  rx_capture_evt,
  output logic                  window_select,
  output ccs_pkg::ccs_mode_t    current_mode,
  output logic [4:0]            data_compare_depth,
  output logic [4:0]            fifo_write_pointer,
  output logic [4:0]            fifo_read_pointer,
  // Interrupt
  output logic                  irq
);

  // ---------------------------------------------------------
  // State
  // ---------------------------------------------------------
  ccs_pkg::ccs_mode_t          mode_request_q;
  ccs_pkg::ccs_mode_t          current_mode_q;
  logic                        stop_in_idle_q;
  logic                        abort_all_tx_q;
  logic                        rx_capture_enable_q;
  logic                        window_select_q;
  logic [4:0]                  depth_q;
  logic [4:0]                  filter_hit_q;
  logic [2:0]                  area_size_q;
  logic [4:0]                  fifo_start_q;
  logic [4:0]                  wr_ptr_q;
  logic [4:0]                  rd_ptr_q;
  logic [`CCS_INT_BITS-1:0]    int_stat_q;
  logic [`CCS_INT_BITS-1:0]    int_mask_q;
  logic [6:0]                  icode_d;
  logic [15:0]                 rdata_d;
  logic [15:0]                 rdata_q;
  logic                        halt_q;
  logic                        capture_q;
  logic                        irq_q;
  logic                        cfg_mode;
  logic                        wr_ctrl1;
  logic                        mode_ok;
  logic [5:0]                  last_buf;
  logic [`CCS_INT_BITS-1:0]    int_set;
  ccs_pkg::ccs_mode_t          req_code;

  assign cfg_mode = (current_mode_q == ccs_pkg::CCS_MODE_CONFIG);
  assign wr_ctrl1 = req.wr && (req.addr == `CCS_IDX_CTRL_ONE);
  assign req_code = ccs_pkg::ccs_mode_t'(req.wdata[`CCS_REQ_HI:`CCS_REQ_LO]);

  // ---------------------------------------------------------
  // Mode request and mode in force
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_request_q <= ccs_pkg::CCS_MODE_CONFIG;
    end else if (wr_ctrl1 && req_code != ccs_pkg::CCS_MODE_RSVD5
                 && req_code != ccs_pkg::CCS_MODE_RSVD6) begin
      mode_request_q <= req_code;
    end
  end

  // Off-bus modes leave at once, except toward config while transmitting; on-bus modes wait for an idle bus
  always_comb begin
    unique case (current_mode_q)
      ccs_pkg::CCS_MODE_CONFIG,
      ccs_pkg::CCS_MODE_DISABLE: mode_ok = 1'b1;
      default:                   mode_ok = eng.bus_idle;
    endcase
    if (mode_request_q == ccs_pkg::CCS_MODE_CONFIG && eng.tx_busy) begin
      mode_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      current_mode_q <= ccs_pkg::CCS_MODE_CONFIG;
    end else if (mode_request_q != current_mode_q && mode_ok) begin
      current_mode_q <= mode_request_q;
    end
  end

  // ---------------------------------------------------------
  // Control one fields
  // ---------------------------------------------------------
  // Idle and capture setup only in config mode; window may move any time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_in_idle_q      <= 1'b0;
      rx_capture_enable_q <= 1'b0;
      window_select_q     <= 1'b0;
    end else if (wr_ctrl1) begin
      window_select_q <= req.wdata[`CCS_BIT_WINDOW];
      if (cfg_mode) begin
        stop_in_idle_q      <= req.wdata[`CCS_BIT_STOP_IDLE];
        rx_capture_enable_q <= req.wdata[`CCS_BIT_CAPTURE];
      end
    end
  end

  // ---------------------------------------------------------
  // Abort all
  // ---------------------------------------------------------
  // Set by software wins over the engine's completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_all_tx_q <= 1'b0;
    end else if (wr_ctrl1 && req.wdata[`CCS_BIT_ABORT]) begin
      abort_all_tx_q <= 1'b1;
    end else if (eng.abort_done) begin
      abort_all_tx_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // Idle halt and receive capture
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= stop_in_idle_q && device_idle;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= rx_capture_enable_q && evt.rx_done;
    end
  end

  // ---------------------------------------------------------
  // Compare depth
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      depth_q <= `CCS_RST_DEPTH;
    end else if (cfg_mode && req.wr && req.addr == `CCS_IDX_CTRL_TWO
                 && req.wdata[`CCS_DEPTH_HI:`CCS_DEPTH_LO] <= `CCS_DEPTH_MAX) begin
      depth_q <= req.wdata[`CCS_DEPTH_HI:`CCS_DEPTH_LO];
    end
  end

  // ---------------------------------------------------------
  // Filter hit
  // ---------------------------------------------------------
  // Reserved hit codes never reach the register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_hit_q <= `CCS_RST_HIT;
    end else if (evt.rx_done && evt.rx_hit <= `CCS_FILTER_MAX) begin
      filter_hit_q <= evt.rx_hit;
    end
  end

  // ---------------------------------------------------------
  // FIFO area and pointers
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      area_size_q  <= `CCS_RST_SIZE;
      fifo_start_q <= `CCS_RST_START;
    end else if (cfg_mode && req.wr && req.addr == `CCS_IDX_FIFO_CTRL) begin
      if (req.wdata[`CCS_SIZE_HI:`CCS_SIZE_LO] != `CCS_SIZE_RSVD) begin
        area_size_q <= req.wdata[`CCS_SIZE_HI:`CCS_SIZE_LO];
      end
      fifo_start_q <= req.wdata[`CCS_START_HI:`CCS_START_LO];
    end
  end

  // Highest buffer index of the allocated area
  always_comb begin
    unique case (area_size_q)
      3'h0:    last_buf = 6'h03;
      3'h1:    last_buf = 6'h05;
      3'h2:    last_buf = 6'h07;
      3'h3:    last_buf = 6'h0B;
      3'h4:    last_buf = 6'h0F;
      3'h5:    last_buf = 6'h17;
      default: last_buf = 6'h1F;
    endcase
  end

  // ---------------------------------------------------------
  // Pointer stepping
  // ---------------------------------------------------------
  function automatic logic [4:0] ccs_next(input logic [4:0] p,
                                          input logic [5:0] last,
                                          input logic [4:0] start);
    if ({1'b0, p} >= last) begin
      ccs_next = start;
    end else begin
      ccs_next = 5'(p + 5'h01);
    end
  endfunction

  // A start beyond the area wraps back to the start at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= `CCS_RST_START;
    end else if (cfg_mode) begin
      wr_ptr_q <= fifo_start_q;
    end else if (evt.fifo_wr) begin
      wr_ptr_q <= ccs_next(wr_ptr_q, last_buf, fifo_start_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_q <= `CCS_RST_START;
    end else if (cfg_mode) begin
      rd_ptr_q <= fifo_start_q;
    end else if (evt.fifo_rd) begin
      rd_ptr_q <= ccs_next(rd_ptr_q, last_buf, fifo_start_q);
    end
  end

  // ---------------------------------------------------------
  // Interrupt status, mask and code
  // ---------------------------------------------------------
  // Buffer bit is a level: it re-arms while any buffer stays pending
  always_comb begin
    int_set                  = '0;
    int_set[`CCS_ST_BUF]     = |buf_pending;
    int_set[`CCS_ST_ERR]     = evt.err;
    int_set[`CCS_ST_WAKE]    = evt.wake;
    int_set[`CCS_ST_OVF]     = evt.ovf;
    int_set[`CCS_ST_FIFO_AF] = evt.fifo_af;
    int_set[`CCS_ST_RX]      = evt.rx_done;
  end

  // Read clears, but an event in the same cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat_q <= '0;
    end else if (req.rd && req.addr == `CCS_IDX_INT_STAT) begin
      int_stat_q <= int_set;
    end else begin
      int_stat_q <= int_stat_q | int_set;
    end
  end

  // ---------------------------------------------------------
  // Mask and request line
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_mask_q <= '0;
    end else if (req.wr && req.addr == `CCS_IDX_INT_MASK) begin
      int_mask_q <= req.wdata[`CCS_INT_BITS-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  // ---------------------------------------------------------
  // Interrupt code
  // ---------------------------------------------------------
  // Error first, then wake, overflow, almost full, then lowest buffer
  always_comb begin
    icode_d = `CCS_IC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (buf_pending[i]) begin
        icode_d = 7'(i);
      end
    end
    if (int_stat_q[`CCS_ST_FIFO_AF]) begin
      icode_d = `CCS_IC_FIFO_AF;
    end
    if (int_stat_q[`CCS_ST_OVF]) begin
      icode_d = `CCS_IC_OVERFLOW;
    end
    if (int_stat_q[`CCS_ST_WAKE]) begin
      icode_d = `CCS_IC_WAKE;
    end
    if (int_stat_q[`CCS_ST_ERR]) begin
      icode_d = `CCS_IC_ERROR;
    end
  end

  // ---------------------------------------------------------
  // Read port
  // ---------------------------------------------------------
  always_comb begin
    rdata_d = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        `CCS_IDX_CTRL_ONE: begin
          rdata_d[`CCS_BIT_STOP_IDLE]          = stop_in_idle_q;
          rdata_d[`CCS_BIT_ABORT]              = abort_all_tx_q;
          rdata_d[`CCS_REQ_HI:`CCS_REQ_LO]     = mode_request_q;
          rdata_d[`CCS_CUR_HI:`CCS_CUR_LO]     = current_mode_q;
          rdata_d[`CCS_BIT_CAPTURE]            = rx_capture_enable_q;
          rdata_d[`CCS_BIT_WINDOW]             = window_select_q;
        end
        `CCS_IDX_CTRL_TWO:  rdata_d[`CCS_DEPTH_HI:`CCS_DEPTH_LO] = depth_q;
        `CCS_IDX_VECTOR: begin
          rdata_d[`CCS_HIT_HI:`CCS_HIT_LO]   = filter_hit_q;
          rdata_d[`CCS_CODE_HI:`CCS_CODE_LO] = icode_d;
        end
        `CCS_IDX_FIFO_CTRL: begin
          rdata_d[`CCS_SIZE_HI:`CCS_SIZE_LO]   = area_size_q;
          rdata_d[`CCS_START_HI:`CCS_START_LO] = fifo_start_q;
        end
        `CCS_IDX_FIFO_STAT: begin
          rdata_d[`CCS_WRP_HI:`CCS_WRP_LO] = wr_ptr_q;
          rdata_d[`CCS_RDP_HI:`CCS_RDP_LO] = rd_ptr_q;
        end
        `CCS_IDX_INT_STAT:  rdata_d[`CCS_INT_BITS-1:0] = int_stat_q;
        `CCS_IDX_INT_MASK:  rdata_d[`CCS_INT_BITS-1:0] = int_mask_q;
        default:            rdata_d = 16'h0000;
      endcase
    end
  end

  // Zero outside the answer cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign module_halt        = halt_q;
  assign abort_all_tx       = abort_all_tx_q;
  assign rx_capture_evt     = capture_q;
  assign window_select      = window_select_q;
  assign current_mode       = current_mode_q;
  assign data_compare_depth = depth_q;
  assign fifo_write_pointer = wr_ptr_q;
  assign fifo_read_pointer  = rd_ptr_q;
  assign irq                = irq_q;

endmodule // ccs_regs

`default_nettype wire

//--- testbench/ccs_regs_props.sv
`default_nettype none

module ccs_regs_props (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Register port
  input var  ccs_pkg::ccs_req_t  req,
  input wire logic [15:0]        reg_rdata,
  // Engine side
  input var  ccs_pkg::ccs_eng_t  eng,
  input var  ccs_pkg::ccs_evt_t  evt,
  input wire logic               device_idle,
  // Outputs
  input wire logic               module_halt,
  input wire logic               abort_all_tx,
  input wire logic               rx_capture_evt,
  input wire logic               window_select,
  input var  ccs_pkg::ccs_mode_t current_mode,
  input wire logic [4:0]         data_compare_depth
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------
  // Access steps
  // ---------------------------------------------------------
  sequence ctrl_read;
    req.rd && req.addr == 4'h0;
  endsequence
  sequence ctrl_write;
    req.wr && req.addr == 4'h0;
  endsequence

  // ---------------------------------------------------------
  // Checks
  // ---------------------------------------------------------
  halt_idle_a: assert property (!device_idle |=> !module_halt)
    else $error("halt without idle");
  abort_clear_a: assert property (abort_all_tx && eng.abort_done
    && !(req.wr && req.addr == 4'h0 && req.wdata[12]) |=> !abort_all_tx)
    else $error("abort bit not cleared");
  rsvd_bit_a: assert property (ctrl_read |=> reg_rdata[11] == 1'b0)
    else $error("reserved bit read one");
  mode_code_a: assert property (!(current_mode inside {ccs_pkg::CCS_MODE_RSVD5, ccs_pkg::CCS_MODE_RSVD6}))
    else $error("reserved mode reported");
  capture_src_a: assert property (!evt.rx_done |=> !rx_capture_evt)
    else $error("capture without receive");
  window_map_a: assert property (ctrl_write |=> window_select == $past(req.wdata[0]))
    else $error("window select not written");
  depth_range_a: assert property (data_compare_depth <= 5'h11)
    else $error("invalid compare depth");
  // Leaving an on-line mode must wait for an idle bus
  mode_idle_a: assert property ($changed(current_mode)
    && !($past(current_mode) inside {ccs_pkg::CCS_MODE_CONFIG, ccs_pkg::CCS_MODE_DISABLE})
    |-> $past(eng.bus_idle))
    else $error("mode changed on busy bus");
  cfg_busy_a: assert property ($changed(current_mode) && current_mode == ccs_pkg::CCS_MODE_CONFIG
    |-> !$past(eng.tx_busy))
    else $error("config entered during transmit");
endmodule // ccs_regs_props

`default_nettype wire

//--- testbench/can_control_status_regs_tb.sv
`default_nettype none

module can_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk;
  logic               rst;
  ccs_pkg::ccs_req_t  req;
  logic [15:0]        reg_rdata;
  ccs_pkg::ccs_eng_t  eng;
  ccs_pkg::ccs_evt_t  evt;
  ccs_pkg::ccs_evt_t  e;
  logic [15:0]        buf_pending;
  logic               device_idle;
  logic               module_halt;
  logic               abort_all_tx;
  logic               rx_capture_evt;
  logic               window_select;
  ccs_pkg::ccs_mode_t current_mode;
  logic [4:0]         data_compare_depth;
  logic [4:0]         fifo_write_pointer;
  logic [4:0]         fifo_read_pointer;
  logic               irq;
  logic [2:0]         codes [5] = '{3'h1, 3'h3, 3'h7, 3'h0, 3'h2};
  int                 fail_count = 0;
  int                 comparisons = 0;

  ccs_regs uut (.clk, .rst, .req, .reg_rdata, .eng, .evt, .buf_pending, .device_idle, .module_halt,
    .abort_all_tx, .rx_capture_evt, .window_select, .current_mode, .data_compare_depth,
    .fifo_write_pointer, .fifo_read_pointer, .irq);

  always #10 clk = ~clk;

  // ---------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask

  task automatic pulse(input ccs_pkg::ccs_evt_t p);
    @(posedge clk);
    evt <= p;
    @(posedge clk);
    evt <= '0;
    @(negedge clk);
  endtask

  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    #(20 * 20000);
    fail_count++;
    conclude();
  end

  // ---------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    eng = '0;
    evt = '0;
    e = '0;
    buf_pending = 16'h0000;
    device_idle = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 16'h0480);
    rd(4'h2, 16'h0040);
    rd(4'h1, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(4'h0, 16'h2c09);
    rd(4'h0, 16'h2489);
    check({15'h0, window_select}, 16'h0001);
    @(posedge clk) device_idle <= 1'b1;
    settle();
    check({15'h0, module_halt}, 16'h0001);
    @(posedge clk) device_idle <= 1'b0;
    settle();
    check({15'h0, module_halt}, 16'h0000);
    e = '0;
    e.rx_done = 1'b1;
    e.rx_hit = 5'h03;
    pulse(e);
    check({15'h0, rx_capture_evt}, 16'h0001);
    e.rx_hit = 5'h12;
    pulse(e);
    rd(4'h2, 16'h0340);
    rd(4'h5, 16'h0020);
    wr(4'h1, 16'h0011);
    wr(4'h1, 16'h0012);
    rd(4'h1, 16'h0011);
    check({11'h000, data_compare_depth}, 16'h0011);
    wr(4'h3, 16'h2002);
    wr(4'h3, 16'he002);
    rd(4'h3, 16'h2002);
    rd(4'h4, 16'h0202);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    check({15'h0, window_select}, 16'h0000);
    check({13'h0, current_mode}, 16'h0000);
    wr(4'h0, 16'h2009);
    rd(4'h0, 16'h0001);
    wr(4'h3, 16'h4007);
    rd(4'h3, 16'h2002);
    e = '0;
    e.fifo_wr = 1'b1;
    repeat (3) pulse(e);
    rd(4'h4, 16'h0502);
    pulse(e);
    rd(4'h4, 16'h0202);
    e = '0;
    e.fifo_rd = 1'b1;
    pulse(e);
    rd(4'h4, 16'h0203);
    check({3'h0, fifo_write_pointer, 3'h0, fifo_read_pointer}, 16'h0203);
    wr(4'h0, 16'h0200);
    rd(4'h0, 16'h0200);
    @(posedge clk) eng.bus_idle <= 1'b1;
    rd(4'h0, 16'h0240);
    check({13'h0, current_mode}, 16'h0002);
    foreach (codes[i]) begin
      wr(4'h0, {5'h0, codes[i], 8'h00});
      rd(4'h0, {5'h0, codes[i], 8'h00} | {8'h0, codes[i], 5'h0});
    end
    wr(4'h0, 16'h0500);
    rd(4'h0, 16'h0240);
    @(posedge clk) eng.tx_busy <= 1'b1;
    wr(4'h0, 16'h0400);
    rd(4'h0, 16'h0440);
    @(posedge clk) eng.tx_busy <= 1'b0;
    rd(4'h0, 16'h0480);
    wr(4'h0, 16'h1400);
    @(negedge clk) check({15'h0, abort_all_tx}, 16'h0001);
    @(posedge clk) eng.abort_done <= 1'b1;
    @(posedge clk) eng.abort_done <= 1'b0;
    @(negedge clk) check({15'h0, abort_all_tx}, 16'h0000);
    rd(4'h0, 16'h0480);
    for (int i = 0; i < 4; i++) begin
      e = '0;
      e.err = (i == 0);
      e.wake = (i == 1);
      e.ovf = (i == 2);
      e.fifo_af = (i == 3);
      pulse(e);
      rd(4'h2, 16'(16'h0341 + i));
      rd(4'h5, 16'h0002 << i);
    end
    e = '0;
    e.err = 1'b1;
    e.wake = 1'b1;
    pulse(e);
    rd(4'h2, 16'h0341);
    rd(4'h5, 16'h0006);
    @(posedge clk) buf_pending <= 16'h0900;
    rd(4'h2, 16'h0308);
    @(posedge clk) buf_pending <= 16'h0000;
    rd(4'h5, 16'h0001);
    rd(4'h5, 16'h0000);
    rd(4'h2, 16'h0340);
    wr(4'h6, 16'h0002);
    e = '0;
    e.wake = 1'b1;
    pulse(e);
    settle();
    check({15'h0, irq}, 16'h0000);
    rd(4'h5, 16'h0004);
    e = '0;
    e.err = 1'b1;
    pulse(e);
    settle();
    check({15'h0, irq}, 16'h0001);
    rd(4'h5, 16'h0002);
    settle();
    check({15'h0, irq}, 16'h0000);
    e = '0;
    e.rx_done = 1'b1;
    e.rx_hit = 5'h05;
    pulse(e);
    check({15'h0, rx_capture_evt}, 16'h0000);
    rd(4'h2, 16'h0540);
    conclude();
  end
endmodule // can_control_status_regs_tb

bind ccs_regs ccs_regs_props u_props (.clk, .rst, .req, .reg_rdata, .eng, .evt, .device_idle, .module_halt,
  .abort_all_tx, .rx_capture_evt, .window_select, .current_mode, .data_compare_depth);

`default_nettype wire
